//--- casc_pkg.sv
// Package for the carrier acquisition sweep controller: widths, encodings,
// timing constants and the carriers exchanged with the demodulator core.
// Assumes a 40 MHz system clock; frequencies are signed hertz offsets.
package casc_pkg;

  // ----------------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------------
  localparam int unsigned FREQ_W = 22;          // Signed Hz offset, covers about +-2.09 MHz
  localparam int unsigned DWELL_W = 16;         // Dwell setting in milliseconds
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned DWELL_UNIT_NS = 1_000_000; // One dwell unit is 1 ms
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned CYC_PER_UNIT = DWELL_UNIT_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W = 16;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CYC_PER_UNIT - 1);

  // ----------------------------------------------------------------------
  // Range limits in hertz
  // ----------------------------------------------------------------------
  localparam logic [FREQ_W-1:0] RANGE_MIN_HZ = 22'h00_0064;  // 100 Hz
  localparam logic [FREQ_W-1:0] RANGE_MAX_HZ = 22'h13_12D0;  // 1.25 MHz

  // ----------------------------------------------------------------------
  // Method encoding and reset value
  // ----------------------------------------------------------------------
  typedef enum logic {
    CASC_DIRECT = 1'b0,
    CASC_SWEEP = 1'b1
  } casc_method_type;
  localparam casc_method_type METHOD_RESET = CASC_DIRECT;

  // Configuration from software
  typedef struct packed {
    casc_method_type method;
    logic [FREQ_W-1:0] range_hz;      // Half-width of the full range
    logic [FREQ_W-1:0] symrate_hz;    // Width of the reduced range
    logic [DWELL_W-1:0] dwell_ms;     // Reduced range dwell time
    logic [FREQ_W-1:0] step_hz;       // Sweep step
  } casc_cfg_type;

  // Commands toward the demodulator core
  typedef struct packed {
    logic search_strongest;           // Direct: find largest carrier in window
    logic try_step;                   // Sweep: try the given offset
    logic signed [FREQ_W-1:0] offset_hz;
    logic signed [FREQ_W-1:0] win_lo_hz;
    logic signed [FREQ_W-1:0] win_hi_hz;
  } casc_cmd_type;

  // Reports from the demodulator core
  typedef struct packed {
    logic done;                       // Attempt finished, one-cycle pulse
    logic detected;                   // Carrier seen at this attempt
    logic locked;                     // Lock level
    logic signed [FREQ_W-1:0] lock_offset_hz;
  } casc_rpt_type;

endpackage

//--- casc_dwell_timer.sv
// Down-counting dwell timer for the reduced reacquisition window.
// Assumes start is a one-cycle pulse; ce freezes it like the rest of the block.
module casc_dwell_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Control
  input wire logic start,
  input wire logic [casc_pkg::DWELL_W-1:0] dwell_ms,
  // Status
  output logic running
);

  logic [casc_pkg::TICK_W-1:0] tick_q;
  logic [casc_pkg::DWELL_W-1:0] units_q;

  // ----------------------------------------------------------------------
  // Millisecond prescaler and unit counter
  // ----------------------------------------------------------------------
  // Restart on every start so each loss of lock gets a full dwell
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_q <= '0;
      units_q <= '0;
      running <= 1'b0;
    end else if (ce) begin
      if (start) begin
        tick_q <= '0;
        units_q <= dwell_ms;
        running <= (dwell_ms != '0);
      end else if (running) begin
        if (tick_q == casc_pkg::TICK_LAST) begin
          tick_q <= '0;
          units_q <= units_q - 1'b1;
          if (units_q == casc_pkg::DWELL_W'(1)) begin
            running <= 1'b0;
          end
        end else begin
          tick_q <= tick_q + 1'b1;
        end
      end
    end
  end

endmodule

//--- casc_ctrl.sv
// Carrier acquisition sweep controller: drives the demodulator core through
// direct or stepped acquisition, and reacquisition after loss of lock.
// Assumes the core answers each try with a done pulse and holds locked as a level.
module casc_ctrl (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Configuration
  input wire casc_pkg::casc_cfg_type cfg,
  input wire logic start,
  // Demodulator core
  input wire casc_pkg::casc_rpt_type rpt,
  output casc_pkg::casc_cmd_type cmd,
  // Status
  output logic locked_q,
  output logic reduced_q,
  output casc_pkg::casc_method_type method_q
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_WAIT,
    ST_LOCKED
  } casc_state_type;

  localparam int unsigned FW = casc_pkg::FREQ_W;

  casc_state_type state_q;
  logic signed [FW-1:0] range_w;
  logic signed [FW-1:0] last_lock_q;
  logic signed [FW-1:0] pos_q;
  logic signed [FW-1:0] lo_w;
  logic signed [FW-1:0] hi_w;
  logic signed [FW-1:0] half_sym_w;
  logic signed [FW:0] step_sum_w;
  logic signed [FW-1:0] next_pos_w;
  logic lock_ok_w;
  logic dwell_start_w;
  logic dwell_run_w;

  // ----------------------------------------------------------------------
  // Range clamp
  // ----------------------------------------------------------------------
  // Clamp keeps a bad software value from producing an empty window;
  // both limits are positive, so the unsigned compare is safe
  always_comb begin
    if (cfg.range_hz < casc_pkg::RANGE_MIN_HZ) begin
      range_w = casc_pkg::RANGE_MIN_HZ;
    end else if (cfg.range_hz > casc_pkg::RANGE_MAX_HZ) begin
      range_w = casc_pkg::RANGE_MAX_HZ;
    end else begin
      range_w = cfg.range_hz;
    end
  end

  // ----------------------------------------------------------------------
  // Window bounds
  // ----------------------------------------------------------------------
  // The reduced window follows the last lock offset rather than the
  // nominal centre, so a carrier that drifted is found again quickly
  always_comb begin
    half_sym_w = FW'(cfg.symrate_hz >> 1);
    if (reduced_q) begin
      lo_w = last_lock_q - half_sym_w;
      hi_w = last_lock_q + half_sym_w;
    end else begin
      lo_w = -range_w;
      hi_w = range_w;
    end
  end

  // ----------------------------------------------------------------------
  // Next sweep position
  // ----------------------------------------------------------------------
  // One spare bit so a large step near the top cannot wrap negative
  // and restart the sweep somewhere in the middle of the window
  always_comb begin
    step_sum_w = $signed({pos_q[FW-1], pos_q}) + $signed({1'b0, cfg.step_hz});
    if (step_sum_w > $signed({hi_w[FW-1], hi_w})) begin
      next_pos_w = lo_w;
    end else begin
      next_pos_w = step_sum_w[FW-1:0];
    end
  end

  // A finished attempt that ended in lock
  assign lock_ok_w = rpt.done && rpt.detected && rpt.locked;

  // Dwell restarts on every loss of lock in the sweep method
  assign dwell_start_w = ce && state_q == ST_LOCKED && !rpt.locked
    && method_q == casc_pkg::CASC_SWEEP;

  // ----------------------------------------------------------------------
  // Method latch
  // ----------------------------------------------------------------------
  // Method is sampled only at start so a change mid-search is orderly
  always_ff @(posedge clk) begin
    if (rst) begin
      method_q <= casc_pkg::METHOD_RESET;
    end else if (ce && start) begin
      method_q <= cfg.method;
    end
  end

  // ----------------------------------------------------------------------
  // Acquisition sequencer
  // ----------------------------------------------------------------------
  // IDLE waits for start, ISSUE sends one attempt, WAIT takes the answer,
  // LOCKED holds until the core withdraws lock; only reset or an illegal state leads to IDLE
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      pos_q <= '0;
      last_lock_q <= '0;
      locked_q <= 1'b0;
      reduced_q <= 1'b0;
      cmd <= '0;
    end else if (ce) begin
      cmd.search_strongest <= 1'b0;
      cmd.try_step <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (start) begin
            reduced_q <= 1'b0;
            pos_q <= -range_w;
            state_q <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          cmd.win_lo_hz <= lo_w;
          cmd.win_hi_hz <= hi_w;
          if (method_q == casc_pkg::CASC_DIRECT) begin
            cmd.search_strongest <= 1'b1;
            cmd.offset_hz <= '0;
          end else begin
            cmd.try_step <= 1'b1;
            cmd.offset_hz <= pos_q;
          end
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          // A lock reported on the very cycle the dwell runs out still
          // counts; the reduced search ends once lock is taken
          if (lock_ok_w) begin
            last_lock_q <= rpt.lock_offset_hz;
            locked_q <= 1'b1;
            reduced_q <= 1'b0;
            state_q <= ST_LOCKED;
          end else if (reduced_q && !dwell_run_w) begin
            reduced_q <= 1'b0;
            pos_q <= -range_w;
            state_q <= ST_ISSUE;
          end else if (rpt.done) begin
            if (method_q == casc_pkg::CASC_SWEEP) begin
              pos_q <= next_pos_w;
            end
            state_q <= ST_ISSUE;
          end
        end
        ST_LOCKED: begin
          // Command offset and position held while lock stands; last_lock_q follows the core
          if (!rpt.locked) begin
            locked_q <= 1'b0;
            state_q <= ST_ISSUE;
            if (method_q == casc_pkg::CASC_SWEEP && cfg.dwell_ms != '0) begin
              reduced_q <= 1'b1;
              pos_q <= last_lock_q - half_sym_w;
            end else begin
              pos_q <= -range_w;
            end
          end else begin
            last_lock_q <= rpt.lock_offset_hz;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Reduced window dwell
  // ----------------------------------------------------------------------
  // Expiry is only acted on in WAIT, so the reduced search may run
  // one cycle past the set dwell when it expires during ISSUE
  casc_dwell_timer u_dwell (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .start(dwell_start_w),
    .dwell_ms(cfg.dwell_ms),
    .running(dwell_run_w)
  );

endmodule

//--- casc_ctrl_monitor.sv
// Port checker for the acquisition controller.
// Assumes ce stays high and the core answers each command once.
module casc_ctrl_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Configuration and core side
  input wire casc_pkg::casc_cfg_type cfg,
  input wire logic start,
  input wire casc_pkg::casc_rpt_type rpt,
  input wire casc_pkg::casc_cmd_type cmd,
  // Status
  input wire logic locked_q,
  input wire logic reduced_q,
  input wire casc_pkg::casc_method_type method_q
);
  // ------
  // Helpers
  // ------
  int rng, nxt, half, dwell, cnt_q;
  logic idle_q;
  // Expected window edges and the next sweep offset, wrapping at the top
  always_comb begin
    rng = int'(cfg.range_hz);
    if (cfg.range_hz < casc_pkg::RANGE_MIN_HZ) rng = int'(casc_pkg::RANGE_MIN_HZ);
    if (cfg.range_hz > casc_pkg::RANGE_MAX_HZ) rng = int'(casc_pkg::RANGE_MAX_HZ);
    nxt = int'(cmd.offset_hz) + int'(cfg.step_hz);
    if (nxt > int'(cmd.win_hi_hz)) nxt = int'(cmd.win_lo_hz);
    half = int'(cfg.symrate_hz >> 1);
    dwell = int'(cfg.dwell_ms) * int'(casc_pkg::CYC_PER_UNIT);
  end
  // Start counts only from idle, and idle is left for good until reset
  always_ff @(posedge clk) idle_q <= rst || (idle_q && !(start && ce));
  // Cycles spent in the reduced window
  always_ff @(posedge clk) cnt_q <= (rst || !reduced_q) ? 0 : cnt_q + 1;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_reset_clears: assert property (
    $fell(rst) |-> method_q == casc_pkg::CASC_DIRECT && !locked_q && !reduced_q)
    else $error("state not cleared by reset");
  chk_first_attempt: assert property (
    idle_q && start && ce |-> ##2 (cfg.method ? cmd.try_step && cmd.offset_hz == -rng : cmd.search_strongest))
    else $error("first attempt wrong");
  chk_direct_window: assert property (
    cmd.search_strongest |-> cmd.offset_hz == 0 && cmd.win_lo_hz == -rng && cmd.win_hi_hz == rng)
    else $error("direct window wrong");
  chk_sweep_step: assert property (
    method_q == casc_pkg::CASC_SWEEP && rpt.done && !rpt.locked && !cmd.try_step && !reduced_q
      && !$past(reduced_q) |-> ##2 cmd.try_step && cmd.offset_hz == $past(nxt, 2))
    else $error("sweep step wrong");
  chk_direct_retry: assert property (
    method_q == casc_pkg::CASC_DIRECT && !rpt.locked && (rpt.done || locked_q) |-> ##2 cmd.search_strongest)
    else $error("direct retry missing");
  chk_lock_set: assert property (
    rpt.done && rpt.detected && rpt.locked |=> locked_q)
    else $error("lock not taken");
  chk_lock_hold: assert property (
    locked_q && rpt.locked |=> locked_q && !cmd.try_step && !cmd.search_strongest && $stable(cmd.offset_hz))
    else $error("offset moved while locked");
  chk_reduced_entry: assert property (
    method_q == casc_pkg::CASC_SWEEP && locked_q && !rpt.locked && cfg.dwell_ms != 0 |=> !locked_q && reduced_q
      ##1 cmd.try_step && cmd.win_lo_hz == $past(rpt.lock_offset_hz, 3) - half
      && cmd.win_hi_hz == $past(rpt.lock_offset_hz, 3) + half)
    else $error("reduced window wrong");
  chk_dwell_span: assert property (
    $fell(reduced_q) && !locked_q && !$past(rst) |-> (cnt_q >= dwell - 2 && cnt_q <= dwell + 24)
      ##[1:2] (cmd.try_step && cmd.offset_hz == -rng))
    else $error("dwell span wrong");
endmodule

bind casc_ctrl casc_ctrl_monitor casc_ctrl_monitor_i (.clk, .rst, .ce, .cfg, .start, .rpt, .cmd, .locked_q,
  .reduced_q, .method_q);

//--- casc_core_model.sv
// Behavioural demodulator core answering acquisition commands.
// Assumes one pulse at a time; a new pulse abandons the attempt in flight.
module casc_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Controller side
  input wire casc_pkg::casc_cmd_type cmd,
  output casc_pkg::casc_rpt_type rpt,
  // Scenario controls
  input wire logic carrier_on,
  input wire logic refuse,
  input wire logic [3:0] delay,
  input wire logic signed [casc_pkg::FREQ_W-1:0] carrier_hz,
  input wire logic [casc_pkg::FREQ_W-1:0] tol_hz
);
  logic busy_q, hit_q, done_q, lock_q, fin;
  logic [3:0] wait_q;
  assign fin = busy_q && wait_q == 4'h0 && !cmd.try_step && !cmd.search_strongest;
  // Answer after a random delay; a hit needs the carrier in window and, for a try_step, within one step above the offset
  always_ff @(posedge clk) begin
    done_q <= fin;
    if (rst) begin
      busy_q <= 1'b0;
    end else if (cmd.search_strongest || cmd.try_step) begin
      busy_q <= 1'b1;
      wait_q <= delay;
      hit_q <= carrier_on && carrier_hz >= cmd.win_lo_hz && carrier_hz <= cmd.win_hi_hz && (cmd.search_strongest
        || (carrier_hz >= cmd.offset_hz && carrier_hz - cmd.offset_hz < $signed(tol_hz)));
    end else if (busy_q) begin
      wait_q <= wait_q - 4'h1;
      busy_q <= !fin;
    end
  end
  // Lock follows an unrefused hit and drops as soon as the carrier goes
  always_ff @(posedge clk) begin
    if (rst || !carrier_on) lock_q <= 1'b0;
    else if (fin) lock_q <= hit_q && !refuse;
  end
  // Offset is junk while unlocked so a stale value is never mistaken
  assign rpt = {done_q, hit_q, lock_q, lock_q ? carrier_hz : ~carrier_hz};
endmodule

//--- casc_ctrl_tb_top.sv
// Self-checking bench for the acquisition controller with a core model.
// Assumes the 40 MHz clock and the one millisecond dwell unit.
module casc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, ce, start, carrier_on, refuse, locked_q, reduced_q;
  logic [3:0] delay;
  logic signed [casc_pkg::FREQ_W-1:0] carrier_hz;
  casc_pkg::casc_cfg_type cfg;
  casc_pkg::casc_cmd_type cmd;
  casc_pkg::casc_rpt_type rpt;
  casc_pkg::casc_method_type method_q;
  int n_fail = 0, n_compared = 0, seed = 21163, r;
  casc_ctrl casc_ctrl_i (.clk(clk), .rst(rst), .ce(ce), .cfg(cfg), .start(start), .rpt(rpt), .cmd(cmd),
    .locked_q(locked_q), .reduced_q(reduced_q), .method_q(method_q));
  casc_core_model casc_core_model_i (.clk(clk), .rst(rst), .cmd(cmd), .rpt(rpt), .carrier_on(carrier_on),
    .refuse(refuse), .delay(delay), .carrier_hz(carrier_hz), .tol_hz(cfg.step_hz));
  // Clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Random answer delay so the core is sometimes prompt, sometimes slow
  always @(negedge clk) delay <= 4'($random(seed));
  function automatic int clamp(input int v);
    return v < 100 ? 100 : (v > 1_250_000 ? 1_250_000 : v);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_for(input logic want);
    for (int i = 0; i < 3000 && locked_q !== want; i++) @(negedge clk);
    check(locked_q, want);
  endtask
  // Reset for four cycles, then start with the given method and range
  task automatic go(input logic m, input int v);
    @(negedge clk);
    rst = 1'b1;
    cfg.method = casc_pkg::casc_method_type'(m);
    cfg.range_hz = 22'(v);
    repeat (4) @(negedge clk);
    check({method_q, locked_q, reduced_q, cmd.try_step, cmd.search_strongest}, 0);
    rst = 1'b0;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog well past the expected run of just over 40000 cycles
  initial begin
    #2_000_000;
    n_fail++;
    complete_run();
  end
  initial begin
    {rst, ce, start, carrier_on, refuse} = 5'b11010;
    cfg = '0;
    cfg.symrate_hz = 22'h00_0190;
    cfg.dwell_ms = 16'h0001;
    r = 1000 + {$random(seed)} % 500_000;
    carrier_hz = 22'(r / 3);
    go(1'b0, r);
    wait_for(1'b1);
    check(cmd.win_lo_hz, -r);
    check(cmd.offset_hz, 0);
    carrier_on = 1'b0;
    wait_for(1'b0);
    carrier_on = 1'b1;
    wait_for(1'b1);
    check(cmd.win_hi_hz, clamp(r));
    $display("direct test done");
    for (int i = 0; i < 2; i++) begin
      r = i ? 16 : 2_000_000;
      go(1'b0, r);
      repeat (3) @(negedge clk);
      check(cmd.win_hi_hz, clamp(r));
    end
    $display("clamp test done");
    // A start while the enable is low must be ignored
    @(negedge clk);
    rst = 1'b1;
    repeat (4) @(negedge clk);
    {rst, ce, start} = 3'b001;
    @(negedge clk);
    {ce, start} = 2'b10;
    @(negedge clk);
    check({cmd.search_strongest, cmd.try_step, locked_q}, 0);
    $display("enable test done");
    r = 900 + {$random(seed)} % 600;
    cfg.step_hz = 22'(r / 3 + 1);
    carrier_hz = 22'(r / 2);
    refuse = 1'b1;
    go(1'b1, r);
    @(negedge clk);
    check(cmd.offset_hz, -r);
    for (int i = 0; i < 2000 && !(rpt.done && rpt.detected); i++) @(negedge clk);
    refuse = 1'b0;
    wait_for(1'b1);
    check(method_q, 1);
    carrier_on = 1'b0;
    repeat (3) @(negedge clk);
    check(reduced_q, 1);
    check(cmd.win_lo_hz, r / 2 - 200);
    carrier_hz = 22'(-r / 2);
    carrier_on = 1'b1;
    repeat (39_000) @(negedge clk);
    check(reduced_q, 1);
    wait_for(1'b1);
    cfg.dwell_ms = '0;
    carrier_on = 1'b0;
    repeat (3) @(negedge clk);
    check(reduced_q, 0);
    $display("sweep test done");
    complete_run();
  end
endmodule
